//--- src/socr_pkg.sv
package socr_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned SOCR_ADR_W = 12;
  localparam int unsigned SOCR_IDX_W = 10;
  localparam int unsigned SOCR_NREG = 5;
  localparam logic [1:0] SOCR_PAGE = 2'h2;

  // Register index is {page, offset}; byte address is four times it
  localparam logic [7:0] SOCR_OFS_HOST = 8'h06;
  localparam logic [7:0] SOCR_OFS_SRC = 8'h38;
  localparam logic [7:0] SOCR_OFS_REF = 8'h39;
  localparam logic [7:0] SOCR_OFS_STAGE = 8'h3b;
  localparam logic [7:0] SOCR_OFS_BRIDGE = 8'h46;

  localparam int unsigned SOCR_SLOT_HOST = 0;
  localparam int unsigned SOCR_SLOT_SRC = 1;
  localparam int unsigned SOCR_SLOT_REF = 2;
  localparam int unsigned SOCR_SLOT_STAGE = 3;
  localparam int unsigned SOCR_SLOT_BRIDGE = 4;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [7:0] SOCR_MASK_HOST = 8'h62;
  localparam logic [7:0] SOCR_MASK_SRC = 8'h01;
  localparam logic [7:0] SOCR_MASK_REF = 8'h01;
  localparam logic [7:0] SOCR_MASK_STAGE = 8'h3f;
  localparam logic [7:0] SOCR_MASK_BRIDGE = 8'h07;

  localparam logic [7:0] SOCR_RST_HOST = 8'h42;
  localparam logic [7:0] SOCR_RST_SRC = 8'h00;
  localparam logic [7:0] SOCR_RST_REF = 8'h00;
  localparam logic [7:0] SOCR_RST_STAGE = 8'h05;
  localparam logic [7:0] SOCR_RST_BRIDGE = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned SOCR_B_LINK_ON = 1;
  localparam int unsigned SOCR_B_FAST = 5;
  localparam int unsigned SOCR_B_DEGLITCH = 6;
  localparam int unsigned SOCR_B_SRC = 0;
  localparam int unsigned SOCR_B_RATIO = 0;
  localparam int unsigned SOCR_B_GAIN_LO = 0;
  localparam int unsigned SOCR_B_GAIN_HI = 2;
  localparam int unsigned SOCR_B_LOOP = 3;
  localparam int unsigned SOCR_B_CAP = 4;
  localparam int unsigned SOCR_B_PULLUP = 5;
  localparam int unsigned SOCR_B_BRIDGE = 0;
  localparam int unsigned SOCR_B_LVL_LO = 1;
  localparam int unsigned SOCR_B_LVL_HI = 2;

  localparam int unsigned SOCR_WORD_W = 14;

  typedef enum logic [2:0] {
    SOCR_GAIN_OFF = 3'b000,
    SOCR_GAIN_X10 = 3'b001,
    SOCR_GAIN_X4 = 3'b010,
    SOCR_GAIN_X2 = 3'b100,
    SOCR_GAIN_X6P67 = 3'b110
  } socr_gain_e;

  typedef enum logic [1:0] {
    SOCR_LVL_2V5 = 2'b00,
    SOCR_LVL_2V0 = 2'b01,
    SOCR_LVL_1V25 = 2'b10,
    SOCR_LVL_1V25_ALT = 2'b11
  } socr_lvl_e;

  // {reserved, x6.67, x2, x4, x10}; off gives all zero
  function automatic logic [4:0] socr_gain_dec(input logic [2:0] code);
    logic [4:0] d;
    d = 5'h10;
    case (code)
      SOCR_GAIN_OFF: d = 5'h00;
      SOCR_GAIN_X10: d = 5'h01;
      SOCR_GAIN_X4: d = 5'h02;
      SOCR_GAIN_X2: d = 5'h04;
      SOCR_GAIN_X6P67: d = 5'h08;
      default: d = 5'h10;
    endcase
    return d;
  endfunction : socr_gain_dec

  // {1.25 V, 2.0 V, 2.5 V}
  function automatic logic [2:0] socr_lvl_dec(input logic [1:0] lvl);
    logic [2:0] d;
    d = 3'h4;
    case (lvl)
      SOCR_LVL_2V5: d = 3'h1;
      SOCR_LVL_2V0: d = 3'h2;
      default: d = 3'h4;
    endcase
    return d;
  endfunction : socr_lvl_dec

endpackage : socr_pkg

//--- src/socr_wr_if.sv
`timescale 1ns/1ns
interface socr_wr_if import socr_pkg::*; ();
  logic ce;
  logic [SOCR_NREG-1:0] we;
  logic [7:0] wdata;

  modport drv (output ce, output we, output wdata);
  modport rcv (input ce, input we, input wdata);
endinterface : socr_wr_if

//--- src/socr_byte_reg.sv
`timescale 1ns/1ns
module socr_byte_reg import socr_pkg::*; #(
  parameter int unsigned IDX = 0,
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk_sys,
  input wire logic rstn,
  socr_wr_if.rcv wr,
  output logic [7:0] q
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Bits outside the mask keep zero whatever is written
  assign q_nxt = (wr.wdata & MASK) | (q_r & ~MASK);
  assign q = q_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q_r <= RST & MASK;
    end else if (wr.ce && wr.we[IDX]) begin
      q_r <= q_nxt;
    end
  end

endmodule : socr_byte_reg

//--- src/socr_top.sv
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
// How it works
// - Link enable output follows host link control bit 1.
// - Bit 5 selects standard class (0) or fast class (1).
// - Bit 6 turns the link glitch filters on; clear bypasses them.
// - Source bit 0 set picks converter data word, else pulse-width path.
// - Reference mode bit 0: one ratiometric, zero absolute.
// - Gain field decodes off, x10, x4, x2, x6.67; other codes reserved.
// - Stage bit 3 closes current-loop switch, enabling the loop output.
// - Stage bit 4 closes the hold capacitor switch.
// - Stage bit 5 closes the gain-input pull-up switch.
// - Bridge bit 0 switches the bridge supply on or off.
// - Bridge bits 2:1 select 2.5 V, 2.0 V or 1.25 V.
module socr_top import socr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [SOCR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [SOCR_WORD_W-1:0] converter_data_word,
  input wire logic pwm_out_on,
  input wire logic [SOCR_WORD_W-1:0] pwm_word,
  output logic link_on,
  output logic link_fast_class,
  output logic link_deglitch_on,
  output logic gain_from_converter,
  output logic [SOCR_WORD_W-1:0] gain_stage_word,
  output logic ratiometric_on,
  output logic voltage_mode_on,
  output logic gain_x10,
  output logic gain_x4,
  output logic gain_x2,
  output logic gain_x6p67,
  output logic gain_code_reserved,
  output logic current_loop_on,
  output logic hold_capacitor_on,
  output logic pullup_on,
  output logic bridge_supply_on,
  output logic [1:0] bridge_level_select,
  output logic bridge_2v5,
  output logic bridge_2v0,
  output logic bridge_1v25
);

  // ************************************************************
  // Wishbone decode
  // ************************************************************
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  wire [SOCR_IDX_W-1:0] idx = wb_adr_i[SOCR_ADR_W-1:2];
  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire hit_host = (idx == {SOCR_PAGE, SOCR_OFS_HOST});
  wire hit_src = (idx == {SOCR_PAGE, SOCR_OFS_SRC});
  wire hit_ref = (idx == {SOCR_PAGE, SOCR_OFS_REF});
  wire hit_stage = (idx == {SOCR_PAGE, SOCR_OFS_STAGE});
  wire hit_bridge = (idx == {SOCR_PAGE, SOCR_OFS_BRIDGE});
  // Only the low byte lane carries register data
  wire wr_go = ce && req && wb_we_i && wb_sel_i[0];
  wire [SOCR_NREG-1:0] hit_vec = {hit_bridge, hit_stage, hit_ref, hit_src, hit_host};

  socr_wr_if wr ();
  assign wr.ce = ce;
  assign wr.wdata = wb_dat_i[7:0];
  assign wr.we = wr_go ? hit_vec : '0;

  // ************************************************************
  // Register bank
  // ************************************************************
  logic [7:0] q_host;
  logic [7:0] q_src;
  logic [7:0] q_ref;
  logic [7:0] q_stage;
  logic [7:0] q_bridge;

  // Masks keep read-only and unused bits at zero
  socr_byte_reg #(.IDX(SOCR_SLOT_HOST), .RST(SOCR_RST_HOST), .MASK(SOCR_MASK_HOST)) u_host (
    .clk_sys(clk_sys), .rstn(rstn), .wr(wr), .q(q_host));
  socr_byte_reg #(.IDX(SOCR_SLOT_SRC), .RST(SOCR_RST_SRC), .MASK(SOCR_MASK_SRC)) u_src (
    .clk_sys(clk_sys), .rstn(rstn), .wr(wr), .q(q_src));
  socr_byte_reg #(.IDX(SOCR_SLOT_REF), .RST(SOCR_RST_REF), .MASK(SOCR_MASK_REF)) u_ref (
    .clk_sys(clk_sys), .rstn(rstn), .wr(wr), .q(q_ref));
  socr_byte_reg #(.IDX(SOCR_SLOT_STAGE), .RST(SOCR_RST_STAGE), .MASK(SOCR_MASK_STAGE)) u_stage (
    .clk_sys(clk_sys), .rstn(rstn), .wr(wr), .q(q_stage));
  socr_byte_reg #(.IDX(SOCR_SLOT_BRIDGE), .RST(SOCR_RST_BRIDGE), .MASK(SOCR_MASK_BRIDGE)) u_bridge (
    .clk_sys(clk_sys), .rstn(rstn), .wr(wr), .q(q_bridge));

  // Unmapped reads answer zero; unmapped writes are acked and dropped
  wire [7:0] rd_byte = ({8{hit_host}} & q_host) | ({8{hit_src}} & q_src) |
                       ({8{hit_ref}} & q_ref) | ({8{hit_stage}} & q_stage) |
                       ({8{hit_bridge}} & q_bridge);
  assign dat_nxt = {24'h00_0000, rd_byte};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce) begin
      ack_r <= req;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ************************************************************
  // Direct control outputs
  // ************************************************************
  assign link_on = q_host[SOCR_B_LINK_ON];
  assign link_fast_class = q_host[SOCR_B_FAST];
  assign link_deglitch_on = q_host[SOCR_B_DEGLITCH];
  assign gain_from_converter = q_src[SOCR_B_SRC];
  assign ratiometric_on = q_ref[SOCR_B_RATIO];
  assign current_loop_on = q_stage[SOCR_B_LOOP];
  assign hold_capacitor_on = q_stage[SOCR_B_CAP];
  assign pullup_on = q_stage[SOCR_B_PULLUP];
  assign bridge_supply_on = q_bridge[SOCR_B_BRIDGE];
  assign bridge_level_select = q_bridge[SOCR_B_LVL_HI:SOCR_B_LVL_LO];

  // ************************************************************
  // Decoded stage controls, registered
  // ************************************************************
  localparam logic [4:0] GAIN_RST = socr_gain_dec(SOCR_RST_STAGE[SOCR_B_GAIN_HI:SOCR_B_GAIN_LO]);
  localparam logic [2:0] LVL_RST = socr_lvl_dec(SOCR_RST_BRIDGE[SOCR_B_LVL_HI:SOCR_B_LVL_LO]);

  logic [4:0] gain_r;
  logic [2:0] lvl_r;
  logic [SOCR_WORD_W-1:0] word_r;
  wire [4:0] gain_nxt = socr_gain_dec(q_stage[SOCR_B_GAIN_HI:SOCR_B_GAIN_LO]);
  wire [2:0] lvl_nxt = socr_lvl_dec(q_bridge[SOCR_B_LVL_HI:SOCR_B_LVL_LO]);
  // Pulse-width path drives zero while its own enable is off
  wire [SOCR_WORD_W-1:0] pwm_sel = pwm_out_on ? pwm_word : '0;
  wire [SOCR_WORD_W-1:0] word_nxt = q_src[SOCR_B_SRC] ? converter_data_word : pwm_sel;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gain_r <= GAIN_RST;
      lvl_r <= LVL_RST;
      word_r <= '0;
    end else if (ce) begin
      gain_r <= gain_nxt;
      lvl_r <= lvl_nxt;
      word_r <= word_nxt;
    end
  end

  assign gain_x10 = gain_r[0];
  assign gain_x4 = gain_r[1];
  assign gain_x2 = gain_r[2];
  assign gain_x6p67 = gain_r[3];
  assign gain_code_reserved = gain_r[4];
  // Reserved codes leave voltage mode off rather than guess a gain
  assign voltage_mode_on = |gain_r[3:0];
  assign bridge_2v5 = lvl_r[0];
  assign bridge_2v0 = lvl_r[1];
  assign bridge_1v25 = lvl_r[2];
  assign gain_stage_word = word_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic first_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      first_r <= 1'b1;
    end else if (ce) begin
      first_r <= 1'b0;
    end
  end

  a_reset_values: assert property (@(posedge clk_sys) disable iff (!rstn)
    first_r |-> (q_host == SOCR_RST_HOST && q_stage == SOCR_RST_STAGE && q_src == 8'h00
                 && q_ref == 8'h00 && q_bridge == 8'h00))
    else $error("register reset values wrong");

  a_link_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_host |=> link_on == $past(wb_dat_i[SOCR_B_LINK_ON]))
    else $error("link enable not written");

  a_speed_class: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_host |=> link_fast_class == $past(wb_dat_i[SOCR_B_FAST]))
    else $error("speed class not written");

  a_filter_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_host |=> link_deglitch_on == $past(wb_dat_i[SOCR_B_DEGLITCH]))
    else $error("filter enable not written");

  a_source_select: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && gain_from_converter |=> gain_stage_word == $past(converter_data_word))
    else $error("converter word not routed");

  a_pwm_source: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !gain_from_converter && !pwm_out_on |=> gain_stage_word == '0)
    else $error("idle pulse-width path not zero");

  a_ref_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_ref ##1 ce |=> gain_stage_word == $past(word_nxt) && ratiometric_on == $past(wb_dat_i[0], 2))
    else $error("reference mode not written");

  a_gain_x10: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && q_stage[2:0] == 3'b001 |=> gain_x10 && voltage_mode_on && !gain_x4 && !gain_x2 && !gain_x6p67)
    else $error("gain 001 not decoded as x10");

  a_gain_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && (q_stage[2:0] == 3'b011 || q_stage[2:0] == 3'b101 || q_stage[2:0] == 3'b111)
    |=> gain_code_reserved && !voltage_mode_on)
    else $error("reserved gain code not flagged");

  a_stage_switches: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_stage |=> {pullup_on, hold_capacitor_on, current_loop_on} == $past(wb_dat_i[5:3]))
    else $error("stage switches not written");

  a_bridge_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && bridge_level_select[1] |=> bridge_1v25 && !bridge_2v5 && !bridge_2v0)
    else $error("bridge level 1x not 1.25 V");

  a_bridge_supply: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_bridge |=> bridge_supply_on == $past(wb_dat_i[SOCR_B_BRIDGE]))
    else $error("bridge supply not written");

  a_ro_bits_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && req && !wb_we_i && hit_host |=> wb_ack_o && (wb_dat_o & ~{24'h00_0000, SOCR_MASK_HOST}) == '0)
    else $error("read-only bits not zero");

  a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Whole bank as one word, so a dropped write is checked in one go
  wire [SOCR_NREG*8-1:0] bank_q = {q_host, q_src, q_ref, q_stage, q_bridge};
  wire [2:0] gain_code = q_stage[SOCR_B_GAIN_HI:SOCR_B_GAIN_LO];

  a_loop_switch: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_stage |=> current_loop_on == $past(wb_dat_i[SOCR_B_LOOP]))
    else $error("current-loop switch not written");

  a_hold_cap: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_stage |=> hold_capacitor_on == $past(wb_dat_i[SOCR_B_CAP]))
    else $error("hold capacitor switch not written");

  a_pullup_switch: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_stage |=> pullup_on == $past(wb_dat_i[SOCR_B_PULLUP]))
    else $error("pull-up switch not written");

  a_source_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_src |=> gain_from_converter == $past(wb_dat_i[SOCR_B_SRC]))
    else $error("source bit not written");

  a_pwm_word: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !gain_from_converter && pwm_out_on |=> gain_stage_word == $past(pwm_word))
    else $error("pulse-width word not routed");

  a_ref_bit: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_go && hit_ref |=> ratiometric_on == $past(wb_dat_i[SOCR_B_RATIO]))
    else $error("reference mode bit not written");

  a_gain_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && gain_code == SOCR_GAIN_OFF |=> !voltage_mode_on && !gain_code_reserved && !gain_x10 && !gain_x4)
    else $error("gain 000 not decoded as off");

  a_gain_x4: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && gain_code == SOCR_GAIN_X4 |=> gain_x4 && voltage_mode_on && !gain_x10 && !gain_x2 && !gain_x6p67)
    else $error("gain 010 not decoded as x4");

  a_gain_x2: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && gain_code == SOCR_GAIN_X2 |=> gain_x2 && voltage_mode_on && !gain_x10 && !gain_x4 && !gain_x6p67)
    else $error("gain 100 not decoded as x2");

  a_gain_x6p67: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && gain_code == SOCR_GAIN_X6P67 |=> gain_x6p67 && voltage_mode_on && !gain_x10 && !gain_x4 && !gain_x2)
    else $error("gain 110 not decoded as x6.67");

  a_level_2v5: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && bridge_level_select == SOCR_LVL_2V5 |=> bridge_2v5 && !bridge_2v0 && !bridge_1v25)
    else $error("bridge level 00 not 2.5 V");

  a_level_2v0: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && bridge_level_select == SOCR_LVL_2V0 |=> bridge_2v0 && !bridge_2v5 && !bridge_1v25)
    else $error("bridge level 01 not 2.0 V");

  a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (q_host & ~SOCR_MASK_HOST) == '0 && (q_src & ~SOCR_MASK_SRC) == '0 && (q_ref & ~SOCR_MASK_REF) == '0
    && (q_stage & ~SOCR_MASK_STAGE) == '0 && (q_bridge & ~SOCR_MASK_BRIDGE) == '0)
    else $error("unused register bit not zero");

  a_stage_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && req && !wb_we_i && hit_stage |=> wb_dat_o == {24'h00_0000, $past(q_stage)})
    else $error("stage register read back wrong");

  a_lane_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && req && wb_we_i && !wb_sel_i[0] |=> bank_q == $past(bank_q))
    else $error("write without low lane changed a register");

  a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && req && wb_we_i && hit_vec == '0 |=> bank_q == $past(bank_q))
    else $error("unmapped write changed a register");

  // Clock enable low must hold every flip-flop, bus side included
  a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ce |=> {bank_q, ack_r, dat_r, gain_r, lvl_r, word_r} == $past({bank_q, ack_r, dat_r, gain_r, lvl_r, word_r}))
    else $error("state moved while clock enable low");

  a_ack_answer: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

endmodule : socr_top

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top import socr_pkg::*;;
  // ************************************************************
  // Stimulus and model
  // ************************************************************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [SOCR_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [SOCR_WORD_W-1:0] converter_data_word = '0;
  logic pwm_out_on = 1'b0;
  logic [SOCR_WORD_W-1:0] pwm_word = '0;
  logic link_on, link_fast_class, link_deglitch_on, gain_from_converter, ratiometric_on;
  logic [SOCR_WORD_W-1:0] gain_stage_word;
  logic voltage_mode_on, gain_x10, gain_x4, gain_x2, gain_x6p67, gain_code_reserved;
  logic current_loop_on, hold_capacitor_on, pullup_on, bridge_supply_on;
  logic [1:0] bridge_level_select;
  logic bridge_2v5, bridge_2v0, bridge_1v25;
  logic [7:0] exp_reg [SOCR_NREG];
  logic [15:0] seed;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cyc_cnt = 0;

  always #5 clk_sys = ~clk_sys;

  socr_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .converter_data_word(converter_data_word), .pwm_out_on(pwm_out_on),
    .pwm_word(pwm_word), .link_on(link_on), .link_fast_class(link_fast_class),
    .link_deglitch_on(link_deglitch_on), .gain_from_converter(gain_from_converter),
    .gain_stage_word(gain_stage_word), .ratiometric_on(ratiometric_on), .voltage_mode_on(voltage_mode_on),
    .gain_x10(gain_x10), .gain_x4(gain_x4), .gain_x2(gain_x2), .gain_x6p67(gain_x6p67),
    .gain_code_reserved(gain_code_reserved), .current_loop_on(current_loop_on),
    .hold_capacitor_on(hold_capacitor_on), .pullup_on(pullup_on), .bridge_supply_on(bridge_supply_on),
    .bridge_level_select(bridge_level_select), .bridge_2v5(bridge_2v5), .bridge_2v0(bridge_2v0),
    .bridge_1v25(bridge_1v25));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [7:0] ofs_of(input int slot);
    case (slot)
      0: return SOCR_OFS_HOST;
      1: return SOCR_OFS_SRC;
      2: return SOCR_OFS_REF;
      3: return SOCR_OFS_STAGE;
      default: return SOCR_OFS_BRIDGE;
    endcase
  endfunction : ofs_of

  function automatic logic [7:0] mask_of(input int slot);
    case (slot)
      0: return SOCR_MASK_HOST;
      1: return SOCR_MASK_SRC;
      2: return SOCR_MASK_REF;
      3: return SOCR_MASK_STAGE;
      default: return SOCR_MASK_BRIDGE;
    endcase
  endfunction : mask_of

  // {voltage mode, reserved, x6.67, x2, x4, x10}
  function automatic logic [5:0] exp_gain(input logic [2:0] code);
    case (code)
      3'h0: return 6'h00;
      3'h1: return 6'h21;
      3'h2: return 6'h22;
      3'h4: return 6'h24;
      3'h6: return 6'h28;
      default: return 6'h10;
    endcase
  endfunction : exp_gain

  // {1.25 V, 2.0 V, 2.5 V}; both upper codes give the lowest level
  function automatic logic [2:0] exp_lvl(input logic [1:0] l);
    return (l == 2'h0) ? 3'h1 : (l == 2'h1) ? 3'h2 : 3'h4;
  endfunction : exp_lvl

  // ************************************************************
  // Bus, compare and report tasks
  // ************************************************************
  task automatic test_done();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until ack is seen; idle cycle follows via next entry edge
  task automatic wb_xfer(input logic [11:0] adr, input logic we, input logic [7:0] wd, input logic sel0);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= {seed[3:1], sel0};
    wb_dat_i <= {seed[15:0], seed[7:0], wd};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr_reg(input int slot, input logic [7:0] d, input logic sel0);
    wb_xfer({SOCR_PAGE, ofs_of(slot), 2'b00}, 1'b1, d, sel0);
    if (sel0) exp_reg[slot] = d & mask_of(slot);
  endtask : wr_reg

  task automatic rd_all();
    for (int i = 0; i < SOCR_NREG; i++) begin
      wb_xfer({SOCR_PAGE, ofs_of(i), 2'b00}, 1'b0, 8'h00, 1'b1);
      chk(rd, {24'h00_0000, exp_reg[i]}, "readback");
    end
  endtask : rd_all

  task automatic check_outs();
    logic [7:0] h, st, b;
    logic [13:0] w;
    h = exp_reg[SOCR_SLOT_HOST];
    st = exp_reg[SOCR_SLOT_STAGE];
    b = exp_reg[SOCR_SLOT_BRIDGE];
    w = exp_reg[SOCR_SLOT_SRC][0] ? converter_data_word : (pwm_out_on ? pwm_word : 14'h0000);
    @(negedge clk_sys);
    chk(link_on, h[1], "link on");
    chk(link_fast_class, h[5], "speed class");
    chk(link_deglitch_on, h[6], "filters");
    chk(gain_from_converter, exp_reg[SOCR_SLOT_SRC][0], "source");
    chk(gain_stage_word, w, "stage word");
    chk(ratiometric_on, exp_reg[SOCR_SLOT_REF][0], "ratio");
    chk({voltage_mode_on, gain_code_reserved, gain_x6p67, gain_x2, gain_x4, gain_x10}, exp_gain(st[2:0]), "gain");
    chk({pullup_on, hold_capacitor_on, current_loop_on}, st[5:3], "switches");
    chk(bridge_supply_on, b[0], "bridge on");
    chk({bridge_level_select, bridge_1v25, bridge_2v0, bridge_2v5}, {b[2:1], exp_lvl(b[2:1])}, "level");
  endtask : check_outs

  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    // Idle pulse-width path, so the word output may match its reset value
    pwm_out_on <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    exp_reg = '{SOCR_RST_HOST, SOCR_RST_SRC, SOCR_RST_REF, SOCR_RST_STAGE, SOCR_RST_BRIDGE};
    check_outs();
    rd_all();
  endtask : do_reset

  // ************************************************************
  // Timeout and main sequence
  // ************************************************************
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      test_done();
    end
  end

  initial begin
    seed = 16'h3720;
    do_reset();
    wb_xfer({SOCR_PAGE, 8'h3a, 2'b00}, 1'b1, 8'hff, 1'b1);
    wb_xfer({2'h1, SOCR_OFS_STAGE, 2'b00}, 1'b1, 8'hff, 1'b1);
    wb_xfer({SOCR_PAGE, 8'h3a, 2'b00}, 1'b0, 8'h00, 1'b1);
    chk(rd, 32'h0000_0000, "unmapped read");
    rd_all();
    for (int c = 0; c < 8; c++) begin
      seed = lfsr_next(seed);
      wr_reg(SOCR_SLOT_STAGE, {seed[7:3], c[2:0]}, 1'b1);
      check_outs();
    end
    for (int l = 0; l < 4; l++) begin
      seed = lfsr_next(seed);
      wr_reg(SOCR_SLOT_BRIDGE, {seed[7:3], l[1:0], seed[0]}, 1'b1);
      check_outs();
    end
    wr_reg(SOCR_SLOT_HOST, 8'h00, 1'b0);
    rd_all();
    for (int n = 0; n < 80; n++) begin
      seed = lfsr_next(seed);
      @(posedge clk_sys);
      converter_data_word <= seed[13:0];
      pwm_word <= ~seed[14:1];
      pwm_out_on <= seed[15];
      wr_reg(int'(seed[10:8]) % 5, seed[7:0] ^ seed[15:8], 1'b1);
      check_outs();
      if (n % 20 == 19) rd_all();
    end
    // Write held while clock enable is low must wait, then land
    fork
      wr_reg(SOCR_SLOT_BRIDGE, ~exp_reg[SOCR_SLOT_BRIDGE], 1'b1);
      begin
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (3) begin
          check_outs();
          chk(wb_ack_o, 1'b0, "ack while frozen");
        end
        @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    check_outs();
    do_reset();
    test_done();
  end
endmodule : tb_top
